// [tx_wave_map.svh]
`ifndef TX_WAVE_MAP_SVH
`define TX_WAVE_MAP_SVH

`define CH_NUM 2
`define SAMPLE_W 7
`define COL_W 112
`define RAM_DEPTH 64

`define OFS_PULSE_SEL 5'h05
`define OFS_AMP_SCALE 5'h06
`define OFS_WAVE_CTRL 5'h07
`define OFS_WAVE_DATA 5'h08
`define ADDR_IRQ_MASK 6'h14
`define ADDR_IRQ_STATUS 6'h19

`define RST_PULSE_SEL 4'h0
`define RST_AMP_STEP 6'h21
`define SCALE_REF_E1 6'h21
`define SCALE_REF_T1 6'h36
`define SAMPLE_MAX 6'h3F
`define LAST_SUBPHASE 4'hF
`define ARB_MODE_BITS 2'h3
`define DIR_WRITE 1'b0
`define DIR_READ 1'b1

`define TPL_E1_75 4'h0
`define TPL_E1_120 4'h1
`define TPL_T1_0 4'h2
`define TPL_T1_133 4'h3
`define TPL_T1_266 4'h4
`define TPL_T1_399 4'h5
`define TPL_T1_533 4'h6
`define TPL_J1 4'h7
`define TPL_LBO_0 4'h8
`define TPL_LBO_7 4'h9
`define TPL_LBO_15 4'hA
`define TPL_LBO_22 4'hB

`endif

// [tx_wave_pkg.sv]
`include "tx_wave_map.svh"

package tx_wave_pkg;

    typedef logic [`SAMPLE_W-1:0] sample_t;
    typedef logic [`COL_W-1:0] wave_col_t;

    typedef struct packed {
        logic [5:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_s;

    typedef struct packed {
        logic mark;
        logic neg;
    } tx_symbol_s;

    typedef struct packed {
        logic go;
        logic dir;
        logic [1:0] ui;
        logic [3:0] sp;
    } wave_ctrl_s;

    typedef struct packed {
        logic [3:0] pulse_sel;
        logic ref_t1;
        logic [5:0] amp_step;
        wave_ctrl_s ctrl;
        sample_t wave_data;
        logic [3:0] phase;
        tx_symbol_s [3:0] hist;
        sample_t line_sample;
        sample_t [`RAM_DEPTH-1:0] ram;
    } chan_s;

    typedef struct packed {
        chan_s [`CH_NUM-1:0] ch;
        logic [`CH_NUM-1:0] ovf_flag;
        logic [`CH_NUM-1:0] ovf_mask;
        logic irq;
        logic [7:0] rdata;
    } state_s;

endpackage : tx_wave_pkg

// [tx_pulse_waveform_programmer.sv]
// Behaviour
// RULE1 - Select 11xx uses the programmable RAM
// RULE2 - Select also picks 7.5 dB build-out grades
// RULE3 - Pulse spans four UIs, two-bit index
// RULE4 - Sixteen sub-phases per UI, four-bit index
// RULE5 - Samples are 7-bit signed magnitude
// RULE6 - Per channel 64-entry RAM, UI:sub-phase address
// RULE7 - Twelve fixed templates held in ROM
// RULE8 - Software sets indices, data, direction, then go
// RULE9 - Direction 0 writes RAM, 1 reads
// RULE10 - Go moves data between field and RAM
// RULE11 - Scale step changes amplitude by fixed percent
// RULE12 - Software writes scale after loading samples
// RULE13 - Summed overflow sets status flag
// RULE14 - Overflow interrupt only when mask enables
// RULE15 - Scaling only in arbitrary waveform mode
// RULE16 - E1 scale default 100001, 3 percent
// RULE17 - T1 scale default 110110, 2 percent
// RULE18 - E1 75 ohm template values fixed
// RULE19 - E1 120 ohm template values fixed
// RULE20 - T1 short template values fixed
// RULE21 - Go self-clears, read data lands first
//
// Design decision made here: strobed register access.
`timescale 1ns/1ns

`include "tx_wave_map.svh"

module tx_pulse_waveform_programmer
    import tx_wave_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire reg_req_s reg_req_i,
    output logic [7:0] reg_rdata_o,
    input wire logic [`CH_NUM-1:0] subphase_tick_i,
    input wire tx_symbol_s [`CH_NUM-1:0] tx_symbol_i,
    output sample_t [`CH_NUM-1:0] line_sample_o,
    output logic irq_o
);

    // Column of sixteen samples for one template and one UI, sample 1 on top
    function automatic wave_col_t rom_col(input logic [3:0] tpl, input logic [1:0] ui);
        wave_col_t col;
        col = '0;
        case ({tpl, ui}) // RULE7 RULE2
            {`TPL_E1_75, 2'h0}: begin // RULE18
                col = {7'h00, 7'h00, 7'h00, 7'h0C, 7'h30, 7'h30, 7'h30, 7'h30,
                       7'h30, 7'h30, 7'h30, 7'h30, 28'h0};
            end
            {`TPL_E1_120, 2'h0}: begin // RULE19
                col = {7'h00, 7'h00, 7'h00, 7'h0F, 7'h3C, 7'h3C, 7'h3C, 7'h3C,
                       7'h3C, 7'h3C, 7'h3C, 7'h3C, 28'h0};
            end
            {`TPL_T1_0, 2'h0}, {`TPL_J1, 2'h0}, {`TPL_LBO_0, 2'h0}: begin // RULE20
                col = {7'h17, 7'h27, 7'h27, 7'h26, 7'h25, 7'h25, 7'h25, 7'h24,
                       7'h23, 7'h4A, 7'h4A, 7'h49, 7'h47, 7'h45, 7'h44, 7'h43};
            end
            {`TPL_T1_0, 2'h1}, {`TPL_J1, 2'h1}, {`TPL_LBO_0, 2'h1}: begin // RULE20
                col = {7'h42, 7'h41, 98'h0};
            end
            {`TPL_T1_133, 2'h0}: begin
                col = {7'h1B, 7'h2E, 7'h2C, 7'h2A, 7'h29, 7'h28, 7'h27, 7'h26,
                       7'h25, 7'h50, 7'h4F, 7'h4D, 7'h4A, 7'h48, 7'h46, 7'h44};
            end
            {`TPL_T1_266, 2'h0}: begin
                col = {7'h1F, 7'h34, 7'h2F, 7'h2C, 7'h2B, 7'h2A, 7'h29, 7'h28,
                       7'h25, 7'h57, 7'h53, 7'h50, 7'h4B, 7'h48, 7'h46, 7'h44};
            end
            {`TPL_T1_399, 2'h0}: begin
                col = {7'h20, 7'h3B, 7'h35, 7'h2F, 7'h2E, 7'h2D, 7'h2C, 7'h2A,
                       7'h28, 7'h58, 7'h58, 7'h53, 7'h4C, 7'h48, 7'h46, 7'h44};
            end
            {`TPL_T1_533, 2'h0}: begin
                col = {7'h20, 7'h3F, 7'h38, 7'h33, 7'h2F, 7'h2E, 7'h2D, 7'h2C,
                       7'h29, 7'h5F, 7'h5E, 7'h57, 7'h4F, 7'h49, 7'h47, 7'h44};
            end
            {`TPL_T1_133, 2'h1}, {`TPL_T1_266, 2'h1}, {`TPL_T1_399, 2'h1},
            {`TPL_T1_533, 2'h1}: begin
                col = {7'h43, 7'h42, 7'h41, 91'h0};
            end
            {`TPL_LBO_7, 2'h0}: begin
                col = {7'h00, 7'h02, 7'h09, 7'h13, 7'h1D, 7'h25, 7'h2B, 7'h31,
                       7'h36, 7'h3A, 7'h39, 7'h30, 7'h28, 7'h20, 7'h1A, 7'h17};
            end
            {`TPL_LBO_7, 2'h1}: begin
                col = {7'h14, 7'h12, 7'h10, 7'h0E, 7'h0C, 7'h0B, 7'h0A, 7'h09,
                       7'h08, 7'h07, 7'h06, 7'h05, 7'h04, 7'h04, 7'h03, 7'h03};
            end
            {`TPL_LBO_7, 2'h2}: begin
                col = {7'h02, 7'h02, 7'h02, 7'h02, 7'h02, 7'h01, 7'h01, 7'h01,
                       7'h01, 7'h01, 7'h01, 7'h01, 28'h0};
            end
            {`TPL_LBO_15, 2'h0}: begin
                col = {7'h00, 7'h00, 7'h00, 7'h01, 7'h04, 7'h08, 7'h0E, 7'h14,
                       7'h1B, 7'h22, 7'h2A, 7'h30, 7'h35, 7'h37, 7'h38, 7'h37};
            end
            {`TPL_LBO_15, 2'h1}: begin
                col = {7'h35, 7'h33, 7'h30, 7'h2D, 7'h2A, 7'h27, 7'h24, 7'h21,
                       7'h1E, 7'h1C, 7'h1A, 7'h17, 7'h15, 7'h14, 7'h12, 7'h10};
            end
            {`TPL_LBO_15, 2'h2}: begin
                col = {7'h0F, 7'h0D, 7'h0C, 7'h0B, 7'h0A, 7'h09, 7'h08, 7'h07,
                       7'h06, 7'h06, 7'h05, 7'h05, 7'h04, 7'h04, 7'h03, 7'h03};
            end
            {`TPL_LBO_15, 2'h3}: begin
                col = {7'h03, 7'h02, 7'h02, 7'h02, 7'h02, 7'h01, 7'h01, 7'h01,
                       7'h01, 7'h01, 7'h01, 7'h01, 7'h01, 21'h0};
            end
            {`TPL_LBO_22, 2'h0}: begin
                col = {7'h00, 7'h00, 7'h00, 7'h00, 7'h01, 7'h03, 7'h07, 7'h0B,
                       7'h0F, 7'h15, 7'h19, 7'h1C, 7'h20, 7'h23, 7'h27, 7'h2A};
            end
            {`TPL_LBO_22, 2'h1}: begin
                col = {7'h2C, 7'h2E, 7'h30, 7'h31, 7'h32, 7'h32, 7'h32, 7'h31,
                       7'h30, 7'h2E, 7'h2C, 7'h29, 7'h27, 7'h24, 7'h22, 7'h20};
            end
            {`TPL_LBO_22, 2'h2}: begin
                col = {7'h1E, 7'h1C, 7'h1A, 7'h18, 7'h17, 7'h15, 7'h14, 7'h13,
                       7'h11, 7'h10, 7'h0F, 7'h0E, 7'h0D, 7'h0C, 7'h0A, 7'h09};
            end
            {`TPL_LBO_22, 2'h3}: begin
                col = {7'h08, 7'h07, 7'h06, 7'h05, 7'h05, 7'h04, 7'h04, 7'h03,
                       7'h03, 7'h02, 7'h02, 7'h02, 7'h01, 7'h01, 7'h01, 7'h01};
            end
            default: begin
                col = '0;
            end
        endcase
        return col;
    endfunction : rom_col

    function automatic sample_t rom_sample(input logic [3:0] tpl, input logic [1:0] ui,
                                           input logic [3:0] sp);
        wave_col_t col;
        col = rom_col(tpl, ui);
        return col[int'(`LAST_SUBPHASE - sp) * `SAMPLE_W +: `SAMPLE_W];
    endfunction : rom_sample

    state_s q;
    state_s d;
    logic [`CH_NUM-1:0] ovf_ev;

    always_comb begin
        logic cb;
        logic arb;
        logic eff_neg;
        logic [5:0] idx;
        logic [5:0] ref_v;
        logic [7:0] rval;
        logic [7:0] mag_abs;
        logic [13:0] prod;
        logic [13:0] scaled;
        logic signed [9:0] acc;
        sample_t v;
        d = q;
        ovf_ev = '0;
        cb = 1'b0;
        arb = 1'b0;
        eff_neg = 1'b0;
        idx = '0;
        ref_v = `SCALE_REF_E1;
        rval = '0;
        mag_abs = '0;
        prod = '0;
        scaled = '0;
        acc = '0;
        v = '0;
        for (int c = 0; c < `CH_NUM; c++) begin
            cb = 1'(c);
            // Indirect RAM access requested by the go bit
            idx = {q.ch[c].ctrl.ui, q.ch[c].ctrl.sp}; // RULE3 RULE4 RULE6
            if (q.ch[c].ctrl.go) begin
                if (q.ch[c].ctrl.dir == `DIR_READ) begin // RULE9
                    d.ch[c].wave_data = q.ch[c].ram[idx]; // RULE10 RULE21
                end else begin
                    d.ch[c].ram[idx] = q.ch[c].wave_data; // RULE10
                end
                d.ch[c].ctrl.go = 1'b0; // RULE21
            end
            // Register writes, taken after the access so software sees its value
            if (reg_req_i.wr && reg_req_i.addr == {cb, `OFS_PULSE_SEL}) begin
                d.ch[c].pulse_sel = reg_req_i.wdata[3:0];
            end
            if (reg_req_i.wr && reg_req_i.addr == {cb, `OFS_AMP_SCALE}) begin
                {d.ch[c].ref_t1, d.ch[c].amp_step} = reg_req_i.wdata[6:0];
            end
            if (reg_req_i.wr && reg_req_i.addr == {cb, `OFS_WAVE_CTRL}) begin
                d.ch[c].ctrl = wave_ctrl_s'(reg_req_i.wdata);
            end
            if (reg_req_i.wr && reg_req_i.addr == {cb, `OFS_WAVE_DATA}) begin
                d.ch[c].wave_data = reg_req_i.wdata[`SAMPLE_W-1:0];
            end
            // Register reads
            if (reg_req_i.rd && reg_req_i.addr == {cb, `OFS_PULSE_SEL}) begin
                rval = 8'(q.ch[c].pulse_sel);
            end
            if (reg_req_i.rd && reg_req_i.addr == {cb, `OFS_AMP_SCALE}) begin
                rval = 8'({q.ch[c].ref_t1, q.ch[c].amp_step});
            end
            if (reg_req_i.rd && reg_req_i.addr == {cb, `OFS_WAVE_CTRL}) begin
                rval = 8'(q.ch[c].ctrl);
            end
            if (reg_req_i.rd && reg_req_i.addr == {cb, `OFS_WAVE_DATA}) begin
                rval = 8'(q.ch[c].wave_data);
            end
            // Pulse synthesis, one output sample per sub-phase tick
            if (subphase_tick_i[c]) begin
                d.ch[c].phase = q.ch[c].phase + 4'h1; // RULE4
                if (q.ch[c].phase == `LAST_SUBPHASE) begin
                    d.ch[c].hist = {q.ch[c].hist[2:0], tx_symbol_i[c]}; // RULE3
                end
                arb = (q.ch[c].pulse_sel[3:2] == `ARB_MODE_BITS); // RULE1
                acc = '0;
                for (int k = 0; k < 4; k++) begin
                    if (d.ch[c].hist[k].mark) begin
                        v = arb ? q.ch[c].ram[{2'(k), d.ch[c].phase}] // RULE1 RULE6
                                : rom_sample(q.ch[c].pulse_sel, 2'(k), d.ch[c].phase);
                        // Sample sign folded with the pulse polarity
                        eff_neg = v[`SAMPLE_W-1] ^ d.ch[c].hist[k].neg; // RULE5
                        if (eff_neg) begin
                            acc = acc - 10'(v[`SAMPLE_W-2:0]);
                        end else begin
                            acc = acc + 10'(v[`SAMPLE_W-2:0]);
                        end
                    end
                end
                mag_abs = acc[9] ? 8'(-acc) : 8'(acc);
                ref_v = q.ch[c].ref_t1 ? `SCALE_REF_T1 : `SCALE_REF_E1; // RULE16 RULE17
                prod = 14'(mag_abs) * 14'(q.ch[c].amp_step); // RULE11
                scaled = arb ? prod / 14'(ref_v) : 14'(mag_abs); // RULE15
                if (scaled > 14'(`SAMPLE_MAX)) begin
                    ovf_ev[c] = 1'b1; // RULE13
                    d.ch[c].line_sample = {acc[9], `SAMPLE_MAX};
                end else begin
                    d.ch[c].line_sample = {acc[9], scaled[5:0]};
                end
            end
        end
        if (reg_req_i.wr && reg_req_i.addr == `ADDR_IRQ_MASK) begin
            d.ovf_mask = reg_req_i.wdata[`CH_NUM-1:0];
        end
        if (reg_req_i.rd && reg_req_i.addr == `ADDR_IRQ_MASK) begin
            rval = 8'(q.ovf_mask);
        end
        if (reg_req_i.rd && reg_req_i.addr == `ADDR_IRQ_STATUS) begin
            rval = 8'(q.ovf_flag);
            d.ovf_flag = '0;
        end
        // A new overflow wins over the clear-on-read
        d.ovf_flag = d.ovf_flag | ovf_ev; // RULE13
        d.irq = |(d.ovf_flag & d.ovf_mask); // RULE14
        d.rdata = rval;
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            q <= '0;
            for (int c = 0; c < `CH_NUM; c++) begin
                q.ch[c].pulse_sel <= `RST_PULSE_SEL;
                q.ch[c].amp_step <= `RST_AMP_STEP; // RULE16
            end
        end else begin
            q <= d;
        end
    end

    assign reg_rdata_o = q.rdata;
    assign irq_o = q.irq;

    for (genvar g = 0; g < `CH_NUM; g++) begin : g_out
        assign line_sample_o[g] = q.ch[g].line_sample;
    end

    // Helpers seen only by the checks below
    logic [5:0] addr0;
    sample_t ram_word0;
    assign addr0 = {q.ch[0].ctrl.ui, q.ch[0].ctrl.sp};
    assign ram_word0 = q.ch[0].ram[addr0];
    logic [5:0] addr1;
    sample_t ram_word1;
    assign addr1 = {q.ch[1].ctrl.ui, q.ch[1].ctrl.sp};
    assign ram_word1 = q.ch[1].ram[addr1];

    default clocking cb_main @(posedge core_clk_i);
    endclocking
    default disable iff (!nrst_i);

    sequence go_write_s;
        q.ch[0].ctrl.go && q.ch[0].ctrl.dir == `DIR_WRITE;
    endsequence

    sequence go_read_s;
        q.ch[0].ctrl.go && q.ch[0].ctrl.dir == `DIR_READ && !reg_req_i.wr;
    endsequence

    sequence status_read_s;
        reg_req_i.rd && reg_req_i.addr == `ADDR_IRQ_STATUS;
    endsequence

    chk_go_self_clear: assert property ( // RULE21
        q.ch[0].ctrl.go && !reg_req_i.wr |=> !q.ch[0].ctrl.go)
        else $error("go bit did not clear after access");

    chk_ram_write_back: assert property ( // RULE10
        go_write_s |=> q.ch[0].ram[$past(addr0)] == $past(q.ch[0].wave_data))
        else $error("RAM write did not store sample value");

    chk_ram_read_back: assert property ( // RULE9
        go_read_s |=> q.ch[0].wave_data == $past(ram_word0) && !q.ch[0].ctrl.go)
        else $error("RAM read did not return stored sample");

    chk_ovf_flag_set: assert property ( // RULE13
        ovf_ev[0] |=> q.ovf_flag[0] ##1 (q.ovf_flag[0] || $past(reg_req_i.rd)))
        else $error("overflow event not captured in status");

    chk_status_clear: assert property ( // RULE13
        status_read_s and !ovf_ev[0] |=> !q.ovf_flag[0])
        else $error("status read did not clear the flag");

    chk_irq_gate: assert property ( // RULE14
        !irq_o && ovf_ev == 2'h0 && !reg_req_i.wr |=> !irq_o)
        else $error("interrupt raised without enabled flag");

    chk_irq_raise: assert property ( // RULE14
        ovf_ev[0] && q.ovf_mask[0] && !reg_req_i.wr |=> irq_o)
        else $error("enabled overflow did not raise interrupt");

    chk_phase_wrap: assert property ( // RULE4
        subphase_tick_i[0] && q.ch[0].phase == `LAST_SUBPHASE
        |=> q.ch[0].phase == 4'h0 && q.ch[0].hist[0] == $past(tx_symbol_i[0]))
        else $error("sub-phase wrap or symbol load wrong");

    chk_rdata_slot: assert property (
        !$past(reg_req_i.rd) |-> reg_rdata_o == 8'h00)
        else $error("read data outside its slot");

    chk_rom_e1_75: assert property ( // RULE18
        rom_sample(`TPL_E1_75, 2'h0, 4'h3) == 7'h0C && rom_sample(`TPL_E1_75, 2'h0, 4'hB) == 7'h30
        && rom_sample(`TPL_E1_75, 2'h0, 4'hC) == 7'h00)
        else $error("E1 75 ohm template wrong");

    chk_rom_e1_120: assert property ( // RULE19
        rom_sample(`TPL_E1_120, 2'h0, 4'h3) == 7'h0F && rom_sample(`TPL_E1_120, 2'h0, 4'h4) == 7'h3C)
        else $error("E1 120 ohm template wrong");

    chk_rom_t1_short: assert property ( // RULE20
        rom_sample(`TPL_T1_0, 2'h0, 4'h0) == 7'h17 && rom_sample(`TPL_T1_0, 2'h1, 4'h1) == 7'h41)
        else $error("T1 short template wrong");

    chk_line_saturate: assert property ( // RULE13
        ovf_ev[0] |=> line_sample_o[0][`SAMPLE_W-2:0] == `SAMPLE_MAX)
        else $error("overflowed sample not saturated");

    chk_line_hold: assert property ( // RULE4
        !subphase_tick_i[0] |=> $stable(line_sample_o[0]))
        else $error("line sample changed without a tick");

    chk_phase_step: assert property ( // RULE4
        subphase_tick_i[0] && q.ch[0].phase != `LAST_SUBPHASE
        |=> q.ch[0].phase == $past(q.ch[0].phase) + 4'h1 && $stable(q.ch[0].hist))
        else $error("sub-phase did not advance by one");

    chk_irq_clear: assert property ( // RULE14
        status_read_s ##0 (ovf_ev == 2'h0) |=> !irq_o)
        else $error("interrupt stayed up after status read");

    chk_ram_write_ch1: assert property ( // RULE10
        q.ch[1].ctrl.go && q.ch[1].ctrl.dir == `DIR_WRITE
        |=> q.ch[1].ram[$past(addr1)] == $past(q.ch[1].wave_data))
        else $error("second channel RAM write lost");

    chk_ram_read_ch1: assert property ( // RULE9
        q.ch[1].ctrl.go && q.ch[1].ctrl.dir == `DIR_READ && !reg_req_i.wr
        |=> q.ch[1].wave_data == $past(ram_word1))
        else $error("second channel RAM read wrong");

    chk_rdata_select: assert property ( // RULE1
        reg_req_i.rd && reg_req_i.addr == {1'b0, `OFS_PULSE_SEL}
        |=> reg_rdata_o[3:0] == $past(q.ch[0].pulse_sel) && reg_rdata_o[7:4] == 4'h0)
        else $error("pulse select read back wrong");

endmodule : tx_pulse_waveform_programmer

// [line_dac_model.sv]
`timescale 1ns/1ns

`include "tx_wave_map.svh"

module line_dac_model
    import tx_wave_pkg::*;
(
    input wire logic core_clk_i,
    input wire sample_t [`CH_NUM-1:0] line_sample_i,
    output logic [`CH_NUM-1:0] subphase_tick_o
);
    // Sample converted in each sub-phase slot of the last unit interval played
    sample_t cap [`CH_NUM][16];

    initial begin
        subphase_tick_o = '0;
    end

    // One tick per sub-phase; gap adds idle cycles to model a slow sample clock
    task automatic play(input int ch, input int n, input int gap);
        for (int i = 0; i < n; i++) begin
            subphase_tick_o[ch] <= 1'b1;
            @(posedge core_clk_i);
            subphase_tick_o[ch] <= 1'b0;
            @(posedge core_clk_i);
            @(negedge core_clk_i);
            cap[ch][i % 16] = line_sample_i[ch];
            @(posedge core_clk_i);
            repeat (gap) @(posedge core_clk_i);
        end
    endtask : play

endmodule : line_dac_model

// [tb_tx_pulse_waveform_programmer.sv]
`timescale 1ns/1ns

`include "tx_wave_map.svh"

module tb_tx_pulse_waveform_programmer
    import tx_wave_pkg::*;
;
    logic core_clk_i;
    logic nrst_i;
    reg_req_s reg_req;
    logic [7:0] reg_rdata;
    logic [`CH_NUM-1:0] tick;
    tx_symbol_s [`CH_NUM-1:0] sym;
    sample_t [`CH_NUM-1:0] line;
    logic irq;
    int fail_count;
    int checks_done;

    // Reset contents and an unmapped address: {address, expected}
    localparam logic [15:0] RST_TAB [9] = '{16'h0500, 16'h0621, 16'h0700, 16'h0800,
        16'h1400, 16'h1900, 16'h2621, 16'h2500, 16'h1000};
    // Fixed shapes: {select, sub-phase, negative, expected sample}
    localparam logic [15:0] TPL_TAB [14] = '{16'h030C, 16'h0430, 16'h0C00, 16'h130F,
        16'h15FC, 16'h301B, 16'h401F, 16'h5020, 16'h613F, 16'h794A, 16'h894A, 16'h993A,
        16'hA922, 16'hB915};
    // Scale register and the expected output for a stored sample of 0x20
    localparam logic [15:0] SCL_TAB [5] = '{16'h2120, 16'h2A28, 16'h7620, 16'h7F25,
        16'h201F};

    tx_pulse_waveform_programmer u_dut (
        .core_clk_i(core_clk_i),
        .nrst_i(nrst_i),
        .reg_req_i(reg_req),
        .reg_rdata_o(reg_rdata),
        .subphase_tick_i(tick),
        .tx_symbol_i(sym),
        .line_sample_o(line),
        .irq_o(irq)
    );

    line_dac_model u_dac (
        .core_clk_i(core_clk_i),
        .line_sample_i(line),
        .subphase_tick_o(tick)
    );

    task automatic end_sim();
        $display("checks %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_sim

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t ns: got 0x%h expected 0x%h", $time, got, exp);
        end
    endtask : check

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        reg_req.addr <= a;
        reg_req.wdata <= d;
        reg_req.wr <= 1'b1;
        @(posedge core_clk_i);
        reg_req.wr <= 1'b0;
        @(posedge core_clk_i);
    endtask : wr

    task automatic rd(input logic [5:0] a, input logic [7:0] exp);
        reg_req.addr <= a;
        reg_req.rd <= 1'b1;
        @(posedge core_clk_i);
        reg_req.rd <= 1'b0;
        @(negedge core_clk_i);
        check(reg_rdata, exp);
        @(posedge core_clk_i);
    endtask : rd

    task automatic chk_irq(input logic exp);
        @(negedge core_clk_i);
        check({7'h00, irq}, {7'h00, exp});
        @(posedge core_clk_i);
    endtask : chk_irq

    // One unit interval with a steady symbol; channel 2 runs with a slow tick
    task automatic ui(input int ch, input logic mark, input logic neg);
        sym[ch] <= {mark, neg};
        u_dac.play(ch, 16, ch * 3);
    endtask : ui

    initial begin
        core_clk_i = 1'b0;
        forever #4 core_clk_i = ~core_clk_i;
    end

    initial begin
        repeat (60000) @(posedge core_clk_i);
        fail_count++;
        end_sim();
    end

    initial begin
        nrst_i = 1'b0;
        reg_req = '0;
        sym = '0;
        fail_count = 0;
        checks_done = 0;
        repeat (3) @(posedge core_clk_i);
        nrst_i <= 1'b1;
        @(posedge core_clk_i);
        wr(6'h10, 8'hFF);
        foreach (RST_TAB[i]) rd(RST_TAB[i][13:8], RST_TAB[i][7:0]);
        // Sample RAM access on channel 2, last location, then the same location read on channel 1
        wr(6'h28, 8'h7F);
        wr(6'h27, 8'hBF);
        rd(6'h27, 8'h3F);
        wr(6'h28, 8'h00);
        wr(6'h27, 8'hFF);
        rd(6'h28, 8'h7F);
        rd(6'h27, 8'h7F);
        wr(6'h07, 8'hFF);
        rd(6'h08, 8'h00);
        // Fixed shapes on channel 1, scale left off default to show it is ignored
        u_dac.play(0, 15, 0);
        wr(6'h06, 8'h2A);
        foreach (TPL_TAB[i]) begin
            wr(6'h05, {4'h0, TPL_TAB[i][15:12]});
            repeat (3) ui(0, 1'b0, 1'b0);
            ui(0, 1'b1, TPL_TAB[i][7]);
            check({1'b0, u_dac.cap[0][TPL_TAB[i][11:8]]}, {1'b0, TPL_TAB[i][6:0]});
        end
        wr(6'h05, 8'h02);
        repeat (3) ui(0, 1'b0, 1'b0);
        ui(0, 1'b1, 1'b0);
        check({1'b0, u_dac.cap[0][0]}, 8'h17);
        ui(0, 1'b0, 1'b0);
        check({1'b0, u_dac.cap[0][0]}, 8'h42);
        check({1'b0, u_dac.cap[0][1]}, 8'h41);
        // Two overlapping full-scale pulses overflow the sum
        wr(6'h08, 8'h3F);
        wr(6'h07, 8'h80);
        wr(6'h08, 8'h3F);
        wr(6'h07, 8'h90);
        wr(6'h05, 8'h0C);
        rd(6'h05, 8'h0C);
        wr(6'h06, 8'h21);
        repeat (3) ui(0, 1'b0, 1'b0);
        ui(0, 1'b1, 1'b0);
        check({1'b0, u_dac.cap[0][0]}, 8'h3F);
        ui(0, 1'b1, 1'b0);
        check({1'b0, u_dac.cap[0][0]}, 8'h3F);
        chk_irq(1'b0);
        rd(6'h19, 8'h01);
        rd(6'h19, 8'h00);
        wr(6'h14, 8'h01);
        ui(0, 1'b1, 1'b0);
        chk_irq(1'b1);
        rd(6'h19, 8'h01);
        chk_irq(1'b0);
        // Amplitude steps on channel 2 in programmable mode
        wr(6'h28, 8'h20);
        wr(6'h27, 8'h80);
        wr(6'h25, 8'h0F);
        u_dac.play(1, 15, 0);
        foreach (SCL_TAB[i]) begin
            wr(6'h26, SCL_TAB[i][15:8]);
            ui(1, 1'b1, 1'b0);
            check({1'b0, u_dac.cap[1][0]}, SCL_TAB[i][7:0]);
        end
        end_sim();
    end

endmodule : tb_tx_pulse_waveform_programmer
